// [dv/cpu_pipe_model.sv]
// CPU pipeline model: dispatches instructions and returns tracker entries
`timescale 1ns/1ps
`default_nettype none
module cpu_pipe_model
  import fp_cond_pkg::*;
(
  // Clock
  input wire logic clock,
  // Read stage
  output logic rd_dispatch,
  output op_e rd_op,
  output logic [2:0] rd_opcode_rnd,
  output logic [WORD_W-1:0] rd_src_a,
  output logic [WORD_W-1:0] rd_src_b,
  output logic [WORD_W-1:0] rd_src_c,
  output logic [WORD_W-1:0] rd_intermediate,
  // Write-back
  output logic wb_valid,
  output logic [WORD_W-1:0] wb_exec_result,
  output logic wb_nan_prop,
  output logic [WORD_W-1:0] wb_nan_value,
  output logic wb_flush_ok,
  output logic wb_sub_seen
);
  // Quiet pipeline at time zero
  initial
  begin
    {rd_dispatch, rd_opcode_rnd, rd_src_a, rd_src_b, rd_src_c, rd_intermediate} = '0;
    rd_op = arith2_op;
    {wb_valid, wb_exec_result, wb_nan_prop, wb_nan_value, wb_flush_ok, wb_sub_seen} = '0;
  end
  // One dispatch; returns at the edge that takes it
  task automatic issue(input op_e op, input logic [2:0] rnd, input logic [31:0] a, b, c, i);
    @(posedge clock);
    rd_dispatch <= 1'b1;
    rd_op <= op;
    rd_opcode_rnd <= rnd;
    {rd_src_a, rd_src_b, rd_src_c, rd_intermediate} <= {a, b, c, i};
    @(posedge clock);
    rd_dispatch <= 1'b0;
  endtask
  // One write-back; returns at the edge that takes it
  task automatic retire(input logic [31:0] res, input logic np, input logic [31:0] nv,
    input logic fok, input logic ss);
    @(posedge clock);
    wb_valid <= 1'b1;
    {wb_exec_result, wb_nan_prop, wb_nan_value, wb_flush_ok, wb_sub_seen} <= {res, np, nv, fok, ss};
    @(posedge clock);
    wb_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/fp_operand_result_cond_asserts.sv]
// Port-level checker for operand and result conditioning
`timescale 1ns/1ps
`default_nettype none
module fp_operand_result_cond_asserts
  import fp_cond_pkg::*;
(
  // Clock, reset and bus
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  // Read stage
  input wire logic rd_dispatch,
  input wire op_e rd_op,
  input wire logic [2:0] rd_opcode_rnd,
  input wire logic entry_valid,
  input wire logic entry_nan_prop,
  input wire logic [WORD_W-1:0] entry_nan_value,
  input wire logic [2:0] entry_rnd,
  // Write-back
  input wire logic wb_valid,
  input wire logic wb_nan_prop,
  input wire logic [WORD_W-1:0] wb_nan_value,
  input wire logic wb_flush_ok,
  input wire logic [WORD_W-1:0] wb_exec_result,
  input wire logic wb_sub_seen,
  input wire logic dest_write,
  input wire logic [WORD_W-1:0] dest_data,
  input wire logic subnormal_flag,
  input wire logic subnormal_sticky_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Helpers: a bus request and a conversion dispatch
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic conv = rd_op inside {float_to_int_op, int_to_float_op};
  // Ack rises once and is gone the next cycle
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ////////////////////////////////////////////////////////////
  a_ack_once: assert property (req && !wb_ack_o |=> s_ack_pulse)
    else $error("bus ack is not a single pulse");
  a_conv_opcode_rnd: assert property (rd_dispatch && conv && rd_opcode_rnd[2] |=>
    entry_valid && entry_rnd == $past(rd_opcode_rnd))
    else $error("conversion did not take opcode rounding");
  a_rnd_ignored: assert property (rd_dispatch && !conv &&
    !(rd_op inside {arith2_op, fused_multiply_accumulate_op}) |=> entry_rnd == RND_NONE)
    else $error("rounding select given to a non-rounding op");
  a_rnd_top_set: assert property (rd_dispatch && rd_op == arith2_op |=> entry_rnd[2])
    else $error("rounding select top bit not forced");
  a_nan_quiet: assert property (entry_valid && entry_nan_prop |-> entry_nan_value[QUIET_BIT])
    else $error("propagated NaN not quiet");
  a_nan_replace: assert property (wb_valid && wb_nan_prop |=>
    dest_write && dest_data == $past(wb_nan_value))
    else $error("propagated NaN not written");
  a_plain_result: assert property (wb_valid && !wb_nan_prop && !wb_flush_ok |=>
    dest_data == $past(wb_exec_result))
    else $error("result altered without flush permission");
  a_flag_tracks: assert property (wb_valid && !wb_cyc_i |=> subnormal_flag == $past(wb_sub_seen))
    else $error("subnormal flag does not follow write-back");
  a_sticky_sets: assert property (wb_valid && wb_sub_seen |=> subnormal_sticky_flag)
    else $error("sticky flag not set");
  a_sticky_holds: assert property (subnormal_sticky_flag && !(req && wb_we_i) |=>
    subnormal_sticky_flag)
    else $error("sticky flag cleared without a bus write");
endmodule
bind fp_operand_result_cond fp_operand_result_cond_asserts fp_operand_result_cond_asserts_i (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .rd_dispatch(rd_dispatch), .rd_op(rd_op), .rd_opcode_rnd(rd_opcode_rnd),
  .entry_valid(entry_valid), .entry_nan_prop(entry_nan_prop),
  .entry_nan_value(entry_nan_value), .entry_rnd(entry_rnd), .wb_valid(wb_valid),
  .wb_nan_prop(wb_nan_prop), .wb_nan_value(wb_nan_value), .wb_flush_ok(wb_flush_ok),
  .wb_exec_result(wb_exec_result), .wb_sub_seen(wb_sub_seen), .dest_write(dest_write),
  .dest_data(dest_data), .subnormal_flag(subnormal_flag),
  .subnormal_sticky_flag(subnormal_sticky_flag));
`default_nettype wire

// [dv/fp_operand_result_cond_test.sv]
// Self-checking bench for operand and result conditioning
`timescale 1ns/1ps
`default_nettype none
module fp_operand_result_cond_test
  import fp_cond_pkg::*;
;
  localparam logic [31:0] QN1 = 32'h7FC0_0001, QN3 = 32'h7FC0_0003, SN5 = 32'h7F80_0005;
  localparam logic [31:0] QS5 = 32'h7FC0_0005, ONE = 32'h3F80_0000;
  localparam logic [31:0] NSUB = 32'h8000_0001, NZ = 32'h8000_0000;
  logic clock, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, rd_dispatch, entry_valid;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_src_a, rd_src_b, rd_src_c, rd_intermediate, q;
  logic [31:0] entry_opnd_a, entry_opnd_b, entry_opnd_c, entry_nan_value;
  logic [31:0] wb_exec_result, wb_nan_value, dest_data;
  logic [2:0] rd_opcode_rnd, entry_rnd;
  logic entry_nan_prop, entry_flush_ok, entry_sub_seen, wb_valid, wb_nan_prop, wb_flush_ok;
  logic wb_sub_seen, dest_write, subnormal_flag, subnormal_sticky_flag;
  op_e rd_op;
  int err_total = 0, checks = 0;
  op_e zo[6] = '{arith2_op, float_to_int_op, classify_op, move_op, status_logic_op,
    cpu_transfer_op};
  op_e ig[8] = '{compare_op, classify_op, abs_negate_op, clamp_limit_op, min_max_op, move_op,
    status_logic_op, cpu_transfer_op};
  ////////////////////////////////////////////////////////////
  fp_operand_result_cond fp_operand_result_cond_i (.clock, .rst_n, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .rd_dispatch, .rd_op,
    .rd_opcode_rnd, .rd_src_a, .rd_src_b, .rd_src_c, .rd_intermediate, .entry_valid,
    .entry_opnd_a, .entry_opnd_b, .entry_opnd_c, .entry_nan_prop, .entry_nan_value,
    .entry_flush_ok, .entry_sub_seen, .entry_rnd, .wb_valid, .wb_exec_result, .wb_nan_prop,
    .wb_nan_value, .wb_flush_ok, .wb_sub_seen, .dest_write, .dest_data, .subnormal_flag,
    .subnormal_sticky_flag);
  cpu_pipe_model cpu_pipe_model_i (.clock, .rd_dispatch, .rd_op, .rd_opcode_rnd, .rd_src_a,
    .rd_src_b, .rd_src_c, .rd_intermediate, .wb_valid, .wb_exec_result, .wb_nan_prop,
    .wb_nan_value, .wb_flush_ok, .wb_sub_seen);
  // 100 MHz clock
  always #5 clock = ~clock;
  // Compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Classic Wishbone cycle; ack and read data are taken at the rising edge that shows ack
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, d, 4'hF};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clock);
    err_total++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    {clock, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Reset values and an unmapped place
    bus(1'b0, CTRL_ADDR, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    // NaN selection at dispatch
    cpu_pipe_model_i.issue(arith2_op, 3'h0, QN1, SN5, ONE, ONE);
    #1 chk({entry_valid, entry_nan_prop, entry_nan_value}, {2'b11, QS5});
    cpu_pipe_model_i.issue(arith2_op, 3'h0, QN3, QN1, ONE, ONE);
    #1 chk({entry_nan_prop, entry_nan_value}, {1'b1, QN3});
    cpu_pipe_model_i.issue(fused_multiply_accumulate_op, 3'h0, ONE, ONE, QN3, SN5);
    #1 chk({entry_nan_prop, entry_nan_value}, {1'b1, QS5});
    cpu_pipe_model_i.issue(clamp_limit_op, 3'h0, ONE, QN3, SN5, ONE);
    #1 chk({entry_nan_prop, entry_nan_value}, {1'b1, QS5});
    cpu_pipe_model_i.issue(clamp_limit_op, 3'h0, QN1, QN3, SN5, ONE);
    #1 chk({entry_nan_prop, entry_nan_value}, {1'b1, QN1});
    // Subnormal operands with zeroing off
    cpu_pipe_model_i.issue(arith2_op, 3'h0, NSUB, ONE, ONE, ONE);
    #1 chk({entry_sub_seen, entry_opnd_a}, {1'b1, NSUB});
    cpu_pipe_model_i.issue(float_to_int_op, 3'h0, NSUB, ONE, ONE, ONE);
    #1 chk({entry_sub_seen, entry_opnd_a}, {1'b1, NZ});
    // Zeroing on: only value ops see zero, none raise the exception
    bus(1'b1, CTRL_ADDR, 32'h0000_0001);
    for (int k = 0; k < 6; k++)
    begin
      cpu_pipe_model_i.issue(zo[k], 3'h0, NSUB, NSUB, NSUB, ONE);
      #1 chk({entry_sub_seen, entry_opnd_a}, {1'b0, k < 2 ? NZ : NSUB});
      chk(entry_opnd_b, k < 2 ? NZ : NSUB);
      chk(entry_opnd_c, k < 2 ? NZ : NSUB);
    end
    // Rounding: field 01 against every opcode pattern
    bus(1'b1, CTRL_ADDR, 32'h0000_0100);
    for (int k = 0; k < 8; k++)
    begin
      cpu_pipe_model_i.issue(k[0] ? int_to_float_op : float_to_int_op, k[2:0], ONE, ONE, ONE, ONE);
      #1 chk({entry_flush_ok, entry_rnd}, {1'b0, k[2] ? k[2:0] : 3'h5});
    end
    cpu_pipe_model_i.issue(arith2_op, 3'h7, ONE, ONE, ONE, ONE);
    #1 chk({entry_flush_ok, entry_rnd}, {1'b1, 3'h5});
    for (int k = 0; k < 8; k++)
    begin
      cpu_pipe_model_i.issue(ig[k], 3'h7, ONE, ONE, ONE, ONE);
      #1 chk(entry_rnd, RND_NONE);
    end
    // Write-back: NaN replacement, then flush gated by mask and permission
    cpu_pipe_model_i.retire(ONE, 1'b1, QS5, 1'b1, 1'b0);
    #1 chk({dest_write, dest_data}, {1'b1, QS5});
    bus(1'b1, CTRL_ADDR, 32'h0000_0002);
    cpu_pipe_model_i.retire(NSUB, 1'b0, 32'h0, 1'b1, 1'b0);
    #1 chk(dest_data, NSUB);
    bus(1'b1, CTRL_ADDR, 32'h0000_0006);
    cpu_pipe_model_i.retire(NSUB, 1'b0, 32'h0, 1'b1, 1'b0);
    #1 chk(dest_data, NZ);
    cpu_pipe_model_i.retire(NSUB, 1'b0, 32'h0, 1'b0, 1'b0);
    #1 chk(dest_data, NSUB);
    // Subnormal status: flag follows, sticky holds until software clears it
    cpu_pipe_model_i.retire(ONE, 1'b0, 32'h0, 1'b1, 1'b1);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(q, 32'h0000_0101);
    cpu_pipe_model_i.retire(ONE, 1'b0, 32'h0, 1'b1, 1'b0);
    #1 chk({subnormal_flag, subnormal_sticky_flag}, 2'b01);
    bus(1'b1, STATUS_ADDR, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// [rtl/fp_cond_pkg.sv]
// Constants, opcode classes and register layout for operand and result conditioning
package fp_cond_pkg;
  // Single precision word layout
  localparam int WORD_W = 32;
  localparam int EXP_W = 8;
  localparam int FRAC_W = 23;
  localparam int SIGN_BIT = 31;
  localparam int QUIET_BIT = 22;
  // Candidate operand slots for NaN selection: a, b, c, intermediate
  localparam int NCAND = 4;
  localparam logic [1:0] CAND_A = 2'h0;
  localparam logic [1:0] CAND_B = 2'h1;
  localparam logic [1:0] CAND_C = 2'h2;
  localparam logic [1:0] CAND_I = 2'h3;
  // Register map, byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  // Control register fields
  localparam int ZEROING_POS = 0;
  localparam int FLUSH_POS = 1;
  localparam int UDF_MASK_POS = 2;
  localparam int RND_LO = 8;
  localparam int RND_HI = 9;
  // Status register fields
  localparam int SUB_FLAG_POS = 0;
  localparam int SUB_STICKY_POS = 8;
  // Rounding select encodings
  localparam logic [2:0] RND_FLOOR = 3'h7;
  localparam logic [2:0] RND_CEIL = 3'h6;
  localparam logic [2:0] RND_TRUNC = 3'h5;
  localparam logic [2:0] RND_NEAREST = 3'h4;
  localparam logic [2:0] RND_NONE = 3'h0;
  localparam logic USER_RND_TOP = 1'b1;
  // Instruction classes seen by the read stage
  typedef enum logic [3:0] {
    arith2_op,
    fused_multiply_accumulate_op,
    clamp_limit_op,
    min_max_op,
    abs_negate_op,
    compare_op,
    classify_op,
    status_logic_op,
    move_op,
    cpu_transfer_op,
    float_to_int_op,
    int_to_float_op
  } op_e;
endpackage

// [rtl/fp_operand_result_cond.sv]
// Read-stage operand conditioning and write-back result conditioning
`timescale 1ns/1ps
`default_nettype none
module fp_operand_result_cond
  import fp_cond_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [WORD_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [WORD_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Read stage: instruction dispatched to execute
  input wire logic rd_dispatch,
  input wire op_e rd_op,
  input wire logic [2:0] rd_opcode_rnd,
  input wire logic [WORD_W-1:0] rd_src_a,
  input wire logic [WORD_W-1:0] rd_src_b,
  input wire logic [WORD_W-1:0] rd_src_c,
  input wire logic [WORD_W-1:0] rd_intermediate,
  // Tracker entry and conditioned operands for execute
  output logic entry_valid,
  output logic [WORD_W-1:0] entry_opnd_a,
  output logic [WORD_W-1:0] entry_opnd_b,
  output logic [WORD_W-1:0] entry_opnd_c,
  output logic entry_nan_prop,
  output logic [WORD_W-1:0] entry_nan_value,
  output logic entry_flush_ok,
  output logic entry_sub_seen,
  output logic [2:0] entry_rnd,
  // Write-back stage: tracker entry and execute result return
  input wire logic wb_valid,
  input wire logic [WORD_W-1:0] wb_exec_result,
  input wire logic wb_nan_prop,
  input wire logic [WORD_W-1:0] wb_nan_value,
  input wire logic wb_flush_ok,
  input wire logic wb_sub_seen,
  // Destination write, also the forwarding copy
  output logic dest_write,
  output logic [WORD_W-1:0] dest_data,
  // Exception status
  output logic subnormal_flag,
  output logic subnormal_sticky_flag
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic ack;
    logic [WORD_W-1:0] rdata;
    logic subnormal_zeroing_bit;
    logic result_flush_bit;
    logic underflow_mask_bit;
    logic [1:0] rounding_field;
    logic sub_flag;
    logic sub_sticky;
    logic e_valid;
    logic [WORD_W-1:0] e_a;
    logic [WORD_W-1:0] e_b;
    logic [WORD_W-1:0] e_c;
    logic e_nan_prop;
    logic [WORD_W-1:0] e_nan_value;
    logic e_flush_ok;
    logic e_sub_seen;
    logic [2:0] e_rnd;
    logic d_write;
    logic [WORD_W-1:0] d_data;
  } state_s;

  state_s state;
  state_s next_state;
  logic rst_meta_n;
  logic rst_sync_n;
  logic [WORD_W-1:0] cand [NCAND];
  logic [NCAND-1:0] c_nan;
  logic [NCAND-1:0] c_snan;
  logic [NCAND-1:0] c_sub;
  logic [NCAND-1:0] c_qnan_unused;
  logic [WORD_W-1:0] c_quiet [NCAND];
  logic [WORD_W-1:0] c_zero [NCAND];
  logic res_nan_unused;
  logic res_snan_unused;
  logic res_sub;
  logic res_qnan_unused;
  logic [WORD_W-1:0] res_quiet_unused;
  logic [WORD_W-1:0] res_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One classifier per source plus the intermediate, and one on the result
  assign cand[CAND_A] = rd_src_a;
  assign cand[CAND_B] = rd_src_b;
  assign cand[CAND_C] = rd_src_c;
  assign cand[CAND_I] = rd_intermediate;

  generate
    for (genvar i = 0; i < NCAND; i++)
    begin : g_cls
      fp_value_classify u_cls (
        .value(cand[i]),
        .is_nan(c_nan[i]),
        .is_snan(c_snan[i]),
        .is_sub(c_sub[i]),
        .quiet_nan_value(c_qnan_unused[i]),
        .quieted(c_quiet[i]),
        .signed_zero(c_zero[i])
      );
    end
  endgenerate

  fp_value_classify u_res_cls (
    .value(wb_exec_result),
    .is_nan(res_nan_unused),
    .is_snan(res_snan_unused),
    .is_sub(res_sub),
    .quiet_nan_value(res_qnan_unused),
    .quieted(res_quiet_unused),
    .signed_zero(res_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus, read stage and write-back stage
  always_comb
  begin
    logic [NCAND-1:0] consider;
    logic found_s;
    logic found_q;
    logic [WORD_W-1:0] pick_s;
    logic [WORD_W-1:0] pick_q;
    logic zero_ok;
    logic sub_raise;
    logic [WORD_W-1:0] opnd [3];
    logic req;
    logic sub_evt;
    logic flush_active;
    consider = '0;
    found_s = 1'b0;
    found_q = 1'b0;
    pick_s = '0;
    pick_q = '0;
    zero_ok = 1'b0;
    sub_raise = 1'b0;
    opnd[0] = rd_src_a;
    opnd[1] = rd_src_b;
    opnd[2] = rd_src_c;
    req = wb_cyc_i & wb_stb_i;
    sub_evt = 1'b0;
    flush_active = 1'b0;
    next_state = state;

    // Bus: answer one cycle after the request, drop ack the cycle after
    next_state.ack = req & ~state.ack;
    next_state.rdata = '0;
    if (req && !state.ack && !wb_we_i && wb_adr_i == CTRL_ADDR)
    begin
      next_state.rdata[ZEROING_POS] = state.subnormal_zeroing_bit;
      next_state.rdata[FLUSH_POS] = state.result_flush_bit;
      next_state.rdata[UDF_MASK_POS] = state.underflow_mask_bit;
      next_state.rdata[RND_HI:RND_LO] = state.rounding_field;
    end
    if (req && !state.ack && !wb_we_i && wb_adr_i == STATUS_ADDR)
    begin
      next_state.rdata[SUB_FLAG_POS] = state.sub_flag;
      next_state.rdata[SUB_STICKY_POS] = state.sub_sticky;
    end
    if (req && !state.ack && wb_we_i && wb_adr_i == CTRL_ADDR)
    begin
      if (wb_sel_i[0])
      begin
        next_state.subnormal_zeroing_bit = wb_dat_i[ZEROING_POS];
        next_state.result_flush_bit = wb_dat_i[FLUSH_POS];
        next_state.underflow_mask_bit = wb_dat_i[UDF_MASK_POS];
      end
      if (wb_sel_i[1])
        next_state.rounding_field = wb_dat_i[RND_HI:RND_LO];
    end
    if (req && !state.ack && wb_we_i && wb_adr_i == STATUS_ADDR)
    begin
      if (wb_sel_i[0])
        next_state.sub_flag = wb_dat_i[SUB_FLAG_POS];
      if (wb_sel_i[1])
        next_state.sub_sticky = wb_dat_i[SUB_STICKY_POS];
    end

    // Which operands may supply a propagated NaN
    unique case (rd_op)
      arith2_op, min_max_op:
        consider = 4'h3;
      fused_multiply_accumulate_op:
        consider = '1;
      clamp_limit_op:
        consider = c_nan[CAND_A] ? 4'h1 : 4'h6;
      default:
        consider = '0;
    endcase

    // Lowest index wins within each class; signaling beats quiet
    for (int i = NCAND - 1; i >= 0; i--)
    begin
      if (consider[i] && c_snan[i])
      begin
        found_s = 1'b1;
        pick_s = c_quiet[i];
      end
      if (consider[i] && c_nan[i])
      begin
        found_q = 1'b1;
        pick_q = c_quiet[i];
      end
    end

    // Zeroing applies to every op except status logic, move and CPU transfer, and never classify
    unique case (rd_op)
      status_logic_op, move_op, cpu_transfer_op, classify_op:
        zero_ok = 1'b0;
      default:
        zero_ok = 1'b1;
    endcase

    // Subnormal sources replaced by signed zero; float-to-int always
    for (int i = 0; i < 3; i++)
    begin
      if (zero_ok && c_sub[i])
      begin
        if (state.subnormal_zeroing_bit || rd_op == float_to_int_op)
          opnd[i] = c_zero[i];
        if (!state.subnormal_zeroing_bit)
          sub_raise = 1'b1;
      end
    end

    // Tracker entry capture at dispatch
    next_state.e_valid = rd_dispatch;
    if (rd_dispatch)
    begin
      next_state.e_a = opnd[0];
      next_state.e_b = opnd[1];
      next_state.e_c = opnd[2];
      next_state.e_nan_prop = found_q;
      next_state.e_nan_value = found_s ? pick_s : pick_q;
      next_state.e_sub_seen = sub_raise;
      unique case (rd_op)
        status_logic_op, move_op, cpu_transfer_op, classify_op, float_to_int_op,
        int_to_float_op:
          next_state.e_flush_ok = 1'b0;
        default:
          next_state.e_flush_ok = 1'b1;
      endcase
      unique case (rd_op)
        float_to_int_op, int_to_float_op:
          next_state.e_rnd = rd_opcode_rnd[2] ? rd_opcode_rnd
                           : {USER_RND_TOP, state.rounding_field};
        arith2_op, fused_multiply_accumulate_op:
          next_state.e_rnd = {USER_RND_TOP, state.rounding_field};
        default:
          next_state.e_rnd = RND_NONE;
      endcase
    end

    // Write-back: flush mode read here only, in the write-back cycle
    flush_active = state.result_flush_bit & state.underflow_mask_bit;
    next_state.d_write = wb_valid;
    if (wb_valid)
    begin
      if (wb_nan_prop)
        next_state.d_data = wb_nan_value;
      else if (flush_active && wb_flush_ok && res_sub)
        next_state.d_data = res_zero;
      else
        next_state.d_data = wb_exec_result;
      sub_evt = wb_sub_seen;
      next_state.sub_flag = sub_evt;
    end

    // Hardware set wins over a software clear in the same cycle
    if (sub_evt)
      next_state.sub_sticky = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state <= '0;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign wb_dat_o = state.rdata;
  assign wb_ack_o = state.ack;
  assign entry_valid = state.e_valid;
  assign entry_opnd_a = state.e_a;
  assign entry_opnd_b = state.e_b;
  assign entry_opnd_c = state.e_c;
  assign entry_nan_prop = state.e_nan_prop;
  assign entry_nan_value = state.e_nan_value;
  assign entry_flush_ok = state.e_flush_ok;
  assign entry_sub_seen = state.e_sub_seen;
  assign entry_rnd = state.e_rnd;
  assign dest_write = state.d_write;
  assign dest_data = state.d_data;
  assign subnormal_flag = state.sub_flag;
  assign subnormal_sticky_flag = state.sub_sticky;
endmodule
`default_nettype wire

// [rtl/fp_value_classify.sv]
// Classifies one single precision value: NaN kinds, subnormal, zero
`timescale 1ns/1ps
`default_nettype none
module fp_value_classify
  import fp_cond_pkg::*;
(
  // Value under test
  input wire logic [WORD_W-1:0] value,
  // Classification
  output logic is_nan,
  output logic is_snan,
  output logic is_sub,
  output logic quiet_nan_value,
  output logic [WORD_W-1:0] quieted,
  output logic [WORD_W-1:0] signed_zero
);
  logic exp_ones;
  logic exp_zero;
  logic frac_zero;

  // Field tests on exponent and fraction
  assign exp_ones = &value[WORD_W-2 -: EXP_W];
  assign exp_zero = ~|value[WORD_W-2 -: EXP_W];
  assign frac_zero = ~|value[FRAC_W-1:0];
  assign is_nan = exp_ones & ~frac_zero;
  assign is_snan = is_nan & ~value[QUIET_BIT];
  assign quiet_nan_value = is_nan & value[QUIET_BIT];
  assign is_sub = exp_zero & ~frac_zero;

  // Quieting only sets the quiet bit so the tracer payload survives
  always_comb
  begin
    quieted = value;
    quieted[QUIET_BIT] = 1'b1;
    signed_zero = '0;
    signed_zero[SIGN_BIT] = value[SIGN_BIT];
  end
endmodule
`default_nettype wire
